// ### verilog/lss_consts.vh
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH

// Register map (offset 0x37 is not a multiple of four: index, byte address = 4 x index)
`define LSS_BACKUP_SUPPLY_CONTROL_IDX 8'h37
`define LSS_BACKUP_SUPPLY_CONTROL_ADDR 12'h0dc
`define LSS_STATUS_IDX 8'h38
`define LSS_STATUS_ADDR 12'h0e0
`define LSS_CLOCK_SELECT_IDX 8'h39
`define LSS_CLOCK_SELECT_ADDR 12'h0e4

// Field positions and reset values
`define LSS_BYPASS_FLAG_BIT 0
`define LSS_CTRL_RESERVED 3'h7
`define LSS_CTRL_RESET 1'h0
`define LSS_REG_WIDTH 4

// Status bit positions
`define LSS_ST_SWITCH_BIT 0
`define LSS_ST_FORCED_BIT 1
`define LSS_ST_DONE_BIT 2

// Forced bypass hold time after oscillation start
`define LSS_HOLD_MS 500
`define LSS_CLK_MHZ 100
`define LSS_HOLD_CYCLES (`LSS_HOLD_MS * 1000 * `LSS_CLK_MHZ)

`endif

// ### verilog/lss_hold_timer.v
`timescale 1ns/1ps
`include "lss_consts.vh"

// Counts the forced-bypass interval from oscillation start
module lss_hold_timer #(
	parameter integer HOLD_CYCLES = `LSS_HOLD_CYCLES,
	parameter integer CW = 26
) (
	input wire clk_in,
	input wire srst_in,
	input wire start_in,
	output reg done_out
);
	reg [CW-1:0] count;
	reg running;

	// Starts only after reset, at oscillation start, and stops when done
	always @(posedge clk_in) begin
		if (srst_in) begin
			count <= {CW{1'b0}};
			running <= 1'b0;
			done_out <= 1'b0;
		end else if (!done_out) begin
			if (!running && start_in) begin
				running <= 1'b1;
				count <= {CW{1'b0}};
			end else if (running) begin
				if (count == HOLD_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
					done_out <= 1'b1;
					running <= 1'b0;
				end else begin
					count <= count + {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ### verilog/lss_logic_supply_switch.v
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "lss_consts.vh"

// Summary of operation
// - Switch closes if fast RC clock selected, reset active, or flag set.
// - RC clock selection or reset forces rail onto negative supply.
// - With crystal clock, flag 1 bypasses regulator; flag 0 restores regulation.
// - Reset clears flag; bypass still forced 0.5 s after oscillation start.
// - A 4-bit read/write control register holds the bypass flag.
// - Flag in bit 0; 0 regulated and initial, 1 bypassed.
module lss_logic_supply_switch #(
	parameter integer HOLD_CYCLES = `LSS_HOLD_CYCLES
) (
	// Clock and reset
	input wire CLK_IN,
	input wire SRST_IN,
	// APB slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	output reg [31:0] PRDATA_OUT,
	// Oscillator status
	input wire OSC_STARTED_IN,
	// Analog side
	output reg SUPPLY_BYPASS_SWITCH_OUT
);
	// Register map, one word each, data in the low bits:
	//  control - bit 0 bypass flag, bits 3:1 reserved and read as one
	//  status  - bit 0 switch, bit 1 forced, bit 2 hold done
	//  clock   - bit 0 selects the fast RC clock
	// Hazard: the switch lags its causes by one edge
	// Limitation: the hold timer runs once per reset

	// Register select codes
	localparam [1:0] SEL_CTRL = 2'h0;
	localparam [1:0] SEL_STATUS = 2'h1;
	localparam [1:0] SEL_CLOCK = 2'h2;
	localparam [1:0] SEL_NONE = 2'h3;

	// Control state
	reg bypass_request_flag;
	reg fast_rc_clock_select;
	reg next_flag;
	reg next_clock_select;

	// Bypass decision
	wire hold_done;
	wire forced;
	wire next_switch;

	// Bus decode
	wire apb_setup;
	wire apb_access;
	wire [1:0] reg_sel;
	wire addr_ok;
	wire ctrl_wr;
	wire clock_wr;
	wire read_load;

	// Read path
	wire [3:0] ctrl_view;
	reg [2:0] status_view;
	reg [31:0] next_rdata;

	// Byte address to register select; one decoder for all bus paths
	function [1:0] lss_decode;
		input [11:0] addr;
		begin
			case (addr)
				`LSS_BACKUP_SUPPLY_CONTROL_ADDR: begin
					lss_decode = SEL_CTRL;
				end
				`LSS_STATUS_ADDR: begin
					lss_decode = SEL_STATUS;
				end
				`LSS_CLOCK_SELECT_ADDR: begin
					lss_decode = SEL_CLOCK;
				end
				default: begin
					lss_decode = SEL_NONE;
				end
			endcase
		end
	endfunction

	// Nibble to bus word, upper bits zero
	function [31:0] lss_word;
		input [3:0] nib;
		begin
			lss_word = {28'h0000000, nib};
		end
	endfunction

	// Half-second timer; runs once per reset, from oscillation start
	lss_hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_timer (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.start_in(OSC_STARTED_IN),
		.done_out(hold_done)
	);

	// Forced conditions override the flag
	assign forced = fast_rc_clock_select | SRST_IN | !hold_done;
	// Flag only matters once nothing forces the bypass
	assign next_switch = forced | bypass_request_flag;

	// Switch output registered to keep it glitch-free toward the analog switch
	always @(posedge CLK_IN) begin
		if (SRST_IN) begin
			SUPPLY_BYPASS_SWITCH_OUT <= 1'b1;
		end else begin
			SUPPLY_BYPASS_SWITCH_OUT <= next_switch;
		end
	end

	// Bus phases; zero wait states, so access is the taking edge
	assign apb_setup = PSEL_IN & !PENABLE_IN;
	assign apb_access = PSEL_IN & PENABLE_IN;
	assign reg_sel = lss_decode(PADDR_IN);
	assign addr_ok = (reg_sel != SEL_NONE);

	// Handshake outputs; unmapped addresses answer with an error
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = apb_access & !addr_ok;

	// Write strobes; status is read-only, so writes there are dropped
	assign ctrl_wr = apb_access & PWRITE_IN & (reg_sel == SEL_CTRL);
	assign clock_wr = apb_access & PWRITE_IN & (reg_sel == SEL_CLOCK);

	// Next flag value; reserved control bits ignore writes
	always @* begin
		next_flag = bypass_request_flag;
		if (ctrl_wr) begin
			next_flag = PWDATA_IN[`LSS_BYPASS_FLAG_BIT];
		end
	end

	// Next clock select value
	always @* begin
		next_clock_select = fast_rc_clock_select;
		if (clock_wr) begin
			next_clock_select = PWDATA_IN[0];
		end
	end

	// Flag register; reset clears it, timer still forces the bypass
	always @(posedge CLK_IN) begin
		if (SRST_IN) begin
			bypass_request_flag <= `LSS_CTRL_RESET;
		end else begin
			bypass_request_flag <= next_flag;
		end
	end

	// Clock select register; reset returns to the crystal clock
	always @(posedge CLK_IN) begin
		if (SRST_IN) begin
			fast_rc_clock_select <= 1'b0;
		end else begin
			fast_rc_clock_select <= next_clock_select;
		end
	end

	// Control view; reserved bits read as one
	assign ctrl_view = {`LSS_CTRL_RESERVED, bypass_request_flag};

	// Status view, placed by the field positions
	always @* begin
		status_view = 3'h0;
		status_view[`LSS_ST_SWITCH_BIT] = SUPPLY_BYPASS_SWITCH_OUT;
		status_view[`LSS_ST_FORCED_BIT] = forced;
		status_view[`LSS_ST_DONE_BIT] = hold_done;
	end

	// Read mux; unmapped addresses read as zero
	always @* begin
		next_rdata = 32'h0000_0000;
		case (reg_sel)
			SEL_CTRL: begin
				next_rdata = lss_word(ctrl_view);
			end
			SEL_STATUS: begin
				next_rdata = lss_word({1'b0, status_view});
			end
			SEL_CLOCK: begin
				next_rdata = lss_word({3'h0, fast_rc_clock_select});
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Load in the setup cycle, so data stands through the access phase
	assign read_load = apb_setup & !PWRITE_IN;

	// Read data flop; holds until the next read setup
	always @(posedge CLK_IN) begin
		if (SRST_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (read_load) begin
			PRDATA_OUT <= next_rdata;
		end
	end
endmodule

// ### tb/lss_regulator_model.sv
`timescale 1ns/1ps
// Rail on negative supply while switch closed
module lss_regulator_model (
	input wire bypass_in,
	output wire negative_rail_out
);
	assign negative_rail_out = bypass_in;
endmodule

// ### tb/lss_checker_sva.sv
`timescale 1ns/1ps
module lss_checker #(parameter integer HOLD_CYCLES = 20) (
	input wire CLK_IN, SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT,
	input wire SUPPLY_BYPASS_SWITCH_OUT,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN, PRDATA_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	// Phase decode; switch is registered, so two edges
	wire s = SUPPLY_BYPASS_SWITCH_OUT;
	wire a = PSEL_IN && PENABLE_IN;
	wire p = PSEL_IN && !PENABLE_IN;
	wire w = a && PWRITE_IN && PWDATA_IN[0];
	a_hold_forced: assert property ($fell(SRST_IN) |-> s [*8])
		else $error("forced bypass dropped");
	a_flag_closes: assert property (w && PADDR_IN == 12'h0dc |-> ##2 s)
		else $error("flag left switch open");
	a_rc_closes: assert property (w && PADDR_IN == 12'h0e4 |-> ##2 s)
		else $error("clock select left switch open");
	a_ctrl_read: assert property (p && !PWRITE_IN && PADDR_IN == 12'h0dc
		|=> PRDATA_OUT[31:1] == 31'h7)
		else $error("control read wrong");
	a_read_hold: assert property (!p |=> $stable(PRDATA_OUT))
		else $error("read data moved");
	a_err_unmapped: assert property (a && PADDR_IN > 12'h0e4 |-> PSLVERR_OUT)
		else $error("no error on unmapped");
	a_ready_now: assert property (a |-> PREADY_OUT)
		else $error("wait state seen");
endmodule
bind lss_logic_supply_switch lss_checker #(.HOLD_CYCLES(HOLD_CYCLES)) i_lss_checker (
	.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.SUPPLY_BYPASS_SWITCH_OUT(SUPPLY_BYPASS_SWITCH_OUT), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT));

// ### tb/logic_supply_switch_control_test.sv
`timescale 1ns/1ps
module logic_supply_switch_control_test;
	logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, osc = 0;
	logic [11:0] ad = 0;
	logic [31:0] wd = 0, q;
	logic qe;
	wire [31:0] rd;
	wire rdy, sw, rail, err;
	int failures = 0, compares = 0, cyc = 0;
	always #5 clk = ~clk;
	lss_logic_supply_switch #(.HOLD_CYCLES(20)) i_lss_logic_supply_switch (.CLK_IN(clk),
		.SRST_IN(rst), .PSEL_IN(sel), .PENABLE_IN(en), .PWRITE_IN(wr), .PADDR_IN(ad),
		.PWDATA_IN(wd), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PRDATA_OUT(rd),
		.OSC_STARTED_IN(osc), .SUPPLY_BYPASS_SWITCH_OUT(sw));
	lss_regulator_model i_lss_regulator_model (.bypass_in(sw), .negative_rail_out(rail));
	task chk(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t %h %h", $time, s, e);
		end
	endtask
	// One APB transfer, read data into q
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) {sel, wr, ad, wd} <= {1'b1, w, a, d};
		@(posedge clk) en <= 1;
		do @(posedge clk); while (rdy !== 1);
		q = rd;
		qe = err;
		{sel, en} <= 0;
	endtask
	task rl(input int n, input logic e);
		repeat (n) @(posedge clk);
		#1 chk({31'h0, rail}, {31'h0, e});
	endtask
	task finish_test;
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			failures++;
			finish_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		rl(30, 1);
		ap(0, 12'h0dc, 0);
		chk(q, 32'he);
		osc <= 1;
		rl(10, 1);
		rl(15, 0);
		ap(1, 12'h0dc, 32'hffff_ffff);
		rl(2, 1);
		ap(0, 12'h0dc, 0);
		chk(q, 32'hf);
		ap(1, 12'h0dc, 0);
		rl(2, 0);
		ap(1, 12'h0e4, 1);
		rl(2, 1);
		ap(0, 12'h0e0, 0);
		chk(q, 32'h7);
		ap(0, 12'h100, 0);
		chk(q, 0);
		chk({31'h0, qe}, 32'h1);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		rl(1, 1);
		ap(0, 12'h0dc, 0);
		chk(q, 32'he);
		finish_test;
	end
endmodule
